// File: hw/adc_readout_map.vh
// constants for the converter readout and conversion control block
// assumes: master clock clk_sys, serial lines sampled in that domain
// Notes on behaviour
// R1: serial output changes on rising serial clock; released while chip select high.
// R2: first rising edge gives frame MSB; first falling edge raises data_ready_n.
// R3: host keeps serial input low during a conversion data read.
// R4: eight-channel frame is 24-bit status plus eight 24-bit words, 216 bits.
// R5: status word is 1100, positive lead-off, negative lead-off, four GPIO levels.
// R6: channel words are two's complement, sent most significant bit first.
// R7: a powered-down channel reads zero and keeps its slot.
// R8: four and six channel variants zero trailing slots; frames of 120 or 168.
// R9: status and GPIO bits latched two clocks before data_ready_n falls.
// R10: with chain enable set, extra serial clocks restart the frame from its MSB.
// R11: data_ready_n falls on new data whatever chip select; clocks raise it.
// R12: a read overlapping the next data-ready completes with undamaged data.
// R13: four GPIO pins, each direction set by its own bit.
// R14: levels read back actual pins; writes drive outputs only, inputs unaffected.
// R15: all GPIO pins are inputs after power-on and any reset.
// R16: reset pin low or reset opcode restores defaults, restarts within 18 clocks.
// R17: writing primary or respiration setup resets the decimation filter. Code resets it only while run_reg is set.
// R18: start pin high two clocks or start opcode begins conversions; else none.
// R19: one-conversion bit selects continuous or single-conversion mode.
// R20: start raises data_ready_n; first data after rate-dependent settling delay.
// R21: step input needs three periods; settled data at fourth data-ready pulse.
// R22: stop lets current conversion finish; 16 clocks ahead halts further ones. Code drops the current one if conv_cnt_reg is 16 or more.
// R23: a command byte is decoded every eight clocks; chip select high resets it.
// R24: serial input is captured on each falling serial clock edge.
`ifndef ADC_READOUT_MAP_VH
`define ADC_READOUT_MAP_VH
`define WORD_BITS 24
`define FRAME_BITS 216
`define FRAME_LEN8 8'hD8
`define FRAME_LEN6 8'hA8
`define FRAME_LEN4 8'h78
`define STATUS_MARK 4'hC
`define CH_COUNT 8
`define OP_START 8'h08
`define OP_STOP 8'h0A
`define OP_RESET 8'h06
`define RESET_INIT_TCLK 18
`define RESET_INIT_CYC 5'h12
`define START_MIN_TCLK 2
`define START_MIN_CYC 2'h2
`define HALT_SETUP_TCLK 16
`define HALT_SETUP_CYC 17'h00010
`define STATUS_LEAD_TCLK 2
`define STATUS_LEAD_CYC 2'h2
`define SYNC_INIT 9'h012
`define GPIO_DIR_RESET 4'hF
`endif

// File: hw/adc_readout_conversion_ctrl.v
// conversion sequencing, framed serial readout, gpio and sample fifo
// assumes: serial pins and gpio come from outside clk_sys and are resampled
`timescale 1ns/10ps
`default_nettype none
`include "adc_readout_map.vh"

// sample fifo between the converter core and the frame buffer
module sample_fifo #(
  parameter W = 24,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output reg in_ready,
  output reg out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data = mem_reg[rd_ptr_reg];

  // flags are registered so the ports come from flops
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= (count_next != D[AW:0]);
      out_valid <= (count_next != {(AW+1){1'b0}});
    end
  end

  // storage, no reset needed for data
  always @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule // sample_fifo

module adc_readout_conversion_ctrl #(
  parameter SETTLE_STEP = 288,
  parameter SETTLE_OFFSET = 8
) (
  input wire clk_sys,
  input wire reset_n,
  input wire reset_pin_n,
  input wire start_pin,
  input wire sclk,
  input wire cs_n,
  input wire din,
  output reg sdo,
  output reg sdo_oe,
  output reg data_ready_n,
  input wire [3:0] gpio_pin_in,
  output reg [3:0] gpio_pin_out,
  output reg [3:0] gpio_pin_oe,
  input wire gpio_write,
  input wire [3:0] gpio_dir_wdata,
  input wire [3:0] gpio_level_wdata,
  output reg [3:0] gpio_direction_bits,
  output reg [3:0] gpio_level_bits,
  input wire [7:0] lead_off_pos_status,
  input wire [7:0] lead_off_neg_status,
  input wire [7:0] chan_power_off,
  input wire [1:0] channel_variant,
  input wire chain_enable_bit,
  input wire one_conversion_mode_bit,
  input wire low_power_mode,
  input wire [2:0] rate_select,
  input wire setup_write,
  input wire sample_valid,
  input wire [23:0] sample_data,
  output wire sample_ready,
  output reg filter_reset,
  output reg converting,
  output reg [7:0] cmd_byte,
  output reg cmd_valid
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_LOAD = 2'd2;
  localparam ST_STAT = 2'd3;
  localparam [8:0] PIN_IDLE = `SYNC_INIT;

  // reset release through two flops
  reg [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // three-flop resampling; a change counts when stages two and three agree
  wire [8:0] pin_vec = {gpio_pin_in, reset_pin_n, start_pin, din, cs_n, sclk};
  reg [8:0] s1_reg;
  reg [8:0] s2_reg;
  reg [8:0] s3_reg;
  reg [8:0] flt_reg;
  reg [8:0] flt_d_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg[gi] <= PIN_IDLE[gi];
          s2_reg[gi] <= PIN_IDLE[gi];
          s3_reg[gi] <= PIN_IDLE[gi];
          flt_reg[gi] <= PIN_IDLE[gi];
          flt_d_reg[gi] <= PIN_IDLE[gi];
        end else begin
          s1_reg[gi] <= pin_vec[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            flt_reg[gi] <= s3_reg[gi];
          end
          flt_d_reg[gi] <= flt_reg[gi];
        end
      end
    end
  endgenerate
  wire sclk_rise = flt_reg[0] & ~flt_d_reg[0];
  wire sclk_fall = ~flt_reg[0] & flt_d_reg[0];
  wire sel = ~flt_reg[1];
  wire sdi = flt_reg[2];
  wire start_lvl = flt_reg[3];
  wire pin_rst = ~flt_reg[4];

  // frame assembly: zero slots for powered-down or absent channels
  reg [23:0] chan_mem_reg [0:7];
  reg [23:0] status_reg;
  wire [3:0] nch = (channel_variant == 2'd0) ? 4'd4 : (channel_variant == 2'd1) ? 4'd6 : 4'd8;
  wire [7:0] frame_len = (channel_variant == 2'd0) ? `FRAME_LEN4 :
                         (channel_variant == 2'd1) ? `FRAME_LEN6 : `FRAME_LEN8; // R8
  wire [`FRAME_BITS-1:0] frame_next;
  assign frame_next[215:192] = status_reg; // R4
  generate
    for (gi = 0; gi < `CH_COUNT; gi = gi + 1) begin : g_slot
      // words are passed through untouched, two's complement msb first
      assign frame_next[191-24*gi -: 24] = (chan_power_off[gi] || (gi >= nch)) ?
        24'h000000 : chan_mem_reg[gi]; // R6 R7 R8
    end
  endgenerate

  // settling and period counts scale by powers of two with rate and power mode
  wire [3:0] shift = {1'b0, rate_select} + {3'b000, low_power_mode};
  wire [31:0] settle32 = (SETTLE_STEP << shift) + SETTLE_OFFSET;
  wire [31:0] period32 = (SETTLE_STEP / 4) << shift;
  wire [16:0] settle_cyc = settle32[16:0]; // R20
  wire [16:0] period_cyc = period32[16:0]; // R21

  // serial receive state shared with the sequencer
  reg [6:0] rx_sr_reg;
  reg [2:0] rx_cnt_reg;
  wire [7:0] rx_byte = {rx_sr_reg, sdi};
  wire fall_sel = sclk_fall & sel;
  wire op7_start = fall_sel && (rx_cnt_reg == 3'd6) &&
                   ({1'b0, rx_sr_reg[5:0], sdi} == (`OP_START >> 1)); // R18
  wire op7_stop = fall_sel && (rx_cnt_reg == 3'd6) &&
                  ({1'b0, rx_sr_reg[5:0], sdi} == (`OP_STOP >> 1)); // R22
  wire op8_reset = fall_sel && (rx_cnt_reg == 3'd7) && (rx_byte == `OP_RESET); // R16

  // receive shifter: falling edge capture, byte boundary every eight clocks
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr_reg <= 7'h00;
      rx_cnt_reg <= 3'd0;
      cmd_byte <= 8'h00;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (!sel) begin
        rx_cnt_reg <= 3'd0; // R23
      end else if (sclk_fall) begin
        rx_sr_reg <= rx_byte[6:0]; // R24
        rx_cnt_reg <= rx_cnt_reg + 3'd1;
        if (rx_cnt_reg == 3'd7) begin
          cmd_byte <= rx_byte; // R23
          cmd_valid <= 1'b1;
        end
      end
    end
  end

  // soft reset: pin or opcode, then a fixed initialisation count
  reg [4:0] init_cnt_reg;
  reg init_done_reg;
  wire busy = pin_rst | (init_cnt_reg != 5'd0);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_reg <= 5'd0;
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= (init_cnt_reg == 5'd1) & ~pin_rst;
      if (pin_rst || op8_reset) begin
        init_cnt_reg <= `RESET_INIT_CYC; // R16
      end else if (init_cnt_reg != 5'd0) begin
        init_cnt_reg <= init_cnt_reg - 5'd1;
      end
    end
  end

  // start pin qualification: two clocks high before it counts
  reg [1:0] start_hi_reg;
  wire start_go = start_lvl && (start_hi_reg == `START_MIN_CYC - 2'h1);
  wire start_drop = ~start_lvl & (start_hi_reg == `START_MIN_CYC);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_hi_reg <= 2'd0;
    end else if (!start_lvl) begin
      start_hi_reg <= 2'd0;
    end else if (start_hi_reg != `START_MIN_CYC) begin
      start_hi_reg <= start_hi_reg + 2'd1; // R18
    end
  end

  // sequencer: settle, drain fifo into slots, latch status, signal ready
  reg [1:0] state_reg;
  reg [16:0] conv_cnt_reg;
  reg [2:0] slot_reg;
  reg [1:0] stat_cnt_reg;
  reg run_reg;
  reg publish_reg;
  wire fifo_valid;
  wire [23:0] fifo_data;
  wire go = start_go | op7_start | (init_done_reg & start_lvl) |
            (setup_write & run_reg); // R17
  // no pop while a higher-priority branch skips the load step, else a word is lost
  wire fifo_take = (state_reg == ST_LOAD) & fifo_valid & ~busy & ~go &
                   ~start_drop & ~op7_stop;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= 17'd0;
      slot_reg <= 3'd0;
      stat_cnt_reg <= 2'd0;
      run_reg <= 1'b0;
      publish_reg <= 1'b0;
      status_reg <= 24'h000000;
      data_ready_n <= 1'b1;
      filter_reset <= 1'b0;
      converting <= 1'b0;
    end else begin
      publish_reg <= 1'b0;
      filter_reset <= 1'b0;
      if (sclk_fall) begin
        data_ready_n <= 1'b1; // R2 R11
      end
      if (busy) begin
        state_reg <= ST_IDLE; // R16
        run_reg <= 1'b0;
        data_ready_n <= 1'b1;
        filter_reset <= 1'b1;
      end else if (go) begin
        state_reg <= ST_CONV; // R18
        conv_cnt_reg <= settle_cyc; // R20
        run_reg <= 1'b1;
        data_ready_n <= 1'b1; // R20
        filter_reset <= 1'b1; // R17
      end else if (start_drop || op7_stop) begin
        run_reg <= 1'b0; // R22
        // early enough: the pending result is dropped, later: it completes
        if (state_reg == ST_CONV && conv_cnt_reg >= `HALT_SETUP_CYC) begin
          state_reg <= ST_IDLE; // R22
        end
      end else begin
        case (state_reg)
          ST_IDLE: begin
            state_reg <= ST_IDLE;
          end
          ST_CONV: begin
            if (conv_cnt_reg <= 17'd1) begin
              state_reg <= ST_LOAD;
              slot_reg <= 3'd0;
            end else begin
              conv_cnt_reg <= conv_cnt_reg - 17'd1;
            end
          end
          ST_LOAD: begin
            // stalls while the fifo is empty
            if (fifo_take && slot_reg == 3'd7) begin
              state_reg <= ST_STAT;
              stat_cnt_reg <= `STATUS_LEAD_CYC;
              status_reg <= {`STATUS_MARK, lead_off_pos_status, lead_off_neg_status,
                             gpio_level_bits}; // R5 R9
            end
            if (fifo_take) begin
              slot_reg <= slot_reg + 3'd1;
            end
          end
          ST_STAT: begin
            if (stat_cnt_reg <= 2'd1) begin
              data_ready_n <= 1'b0; // R9 R11
              publish_reg <= 1'b1;
              if (run_reg && !one_conversion_mode_bit) begin
                state_reg <= ST_CONV; // R19
                conv_cnt_reg <= period_cyc; // R21
              end else begin
                state_reg <= ST_IDLE; // R19
                run_reg <= 1'b0;
              end
            end else begin
              stat_cnt_reg <= stat_cnt_reg - 2'd1;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
      converting <= run_reg;
    end
  end

  // slot storage filled from the fifo head
  always @(posedge clk_sys) begin
    if (fifo_take) begin
      chan_mem_reg[slot_reg] <= fifo_data;
    end
  end

  sample_fifo #(
    .W(`WORD_BITS),
    .D(8),
    .AW(3)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(sample_valid),
    .in_data(sample_data),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // output frame: double buffered so a read in flight is never torn
  reg [`FRAME_BITS-1:0] frame_reg;
  reg [`FRAME_BITS-1:0] out_sr_reg;
  reg [7:0] out_idx_reg;
  reg pending_reg;
  wire reading = sel & (out_idx_reg != 8'd0);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= {`FRAME_BITS{1'b0}};
      out_sr_reg <= {`FRAME_BITS{1'b0}};
      out_idx_reg <= 8'd0;
      pending_reg <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      if (publish_reg && reading) begin
        pending_reg <= 1'b1; // R12
      end else if (publish_reg || (pending_reg && !reading)) begin
        frame_reg <= frame_next; // R12
        pending_reg <= 1'b0;
      end
      sdo_oe <= sel; // R1
      if (!sel) begin
        out_idx_reg <= 8'd0;
      end else if (sclk_rise) begin
        if (out_idx_reg == 8'd0) begin
          sdo <= frame_reg[`FRAME_BITS-1]; // R2
          out_sr_reg <= {frame_reg[`FRAME_BITS-2:0], 1'b0};
        end else begin
          sdo <= (out_idx_reg == frame_len) ? 1'b0 : out_sr_reg[`FRAME_BITS-1]; // R1 R6 R8
          out_sr_reg <= {out_sr_reg[`FRAME_BITS-2:0], 1'b0};
        end
        // past the frame end: restart when chained, else hold on zeros
        if (out_idx_reg == frame_len - 8'd1) begin
          out_idx_reg <= chain_enable_bit ? 8'd0 : frame_len; // R10
        end else if (out_idx_reg != frame_len) begin
          out_idx_reg <= out_idx_reg + 8'd1;
        end
      end
    end
  end

  // gpio: 1 in a direction bit means input; writes reach output bits only
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_direction_bits <= `GPIO_DIR_RESET; // R15
      gpio_pin_out <= 4'h0;
      gpio_pin_oe <= 4'h0;
      gpio_level_bits <= 4'h0;
    end else begin
      if (busy) begin
        gpio_direction_bits <= `GPIO_DIR_RESET; // R15
        gpio_pin_out <= 4'h0;
      end else if (gpio_write) begin
        gpio_direction_bits <= gpio_dir_wdata; // R13
        gpio_pin_out <= (gpio_level_wdata & ~gpio_dir_wdata) |
                        (gpio_pin_out & gpio_dir_wdata); // R14
      end
      gpio_pin_oe <= busy ? 4'h0 : ~gpio_direction_bits; // R13
      gpio_level_bits <= flt_reg[8:5]; // R14
    end
  end
endmodule // adc_readout_conversion_ctrl
`default_nettype wire

// File: tb/adc_readout_checker.sv
// port assertions for the readout and conversion control block
// assumes: bound into the top module, one clock domain
`timescale 1ns/10ps
`default_nettype none
module adc_readout_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic start_pin,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdo_oe,
  input wire logic data_ready_n,
  input wire logic [3:0] gpio_pin_out,
  input wire logic [3:0] gpio_pin_oe,
  input wire logic gpio_write,
  input wire logic [3:0] gpio_dir_wdata,
  input wire logic [3:0] gpio_level_wdata,
  input wire logic [3:0] gpio_direction_bits,
  input wire logic setup_write,
  input wire logic filter_reset,
  input wire logic converting,
  input wire logic cmd_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // clocks since the last decoded byte; saturates so idle time never wraps
  logic [7:0] gap_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      gap_reg <= 8'hFF;
    else if (cmd_valid)
      gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF)
      gap_reg <= gap_reg + 8'h01;
  end
  // serial port and data ready
  a_oe_release: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("serial out driven while deselected");
  a_data_ready_n_rise: assert property ($fell(sclk) && !data_ready_n |-> ##[1:8] data_ready_n)
    else $error("data ready not cleared by serial clock");
  a_start_clear: assert property ($rose(start_pin) |-> ##[1:8] data_ready_n)
    else $error("data ready low after start");
  a_cmd_spacing: assert property (cmd_valid |-> gap_reg >= 8'h3C)
    else $error("command bytes closer than eight clocks");
  // device reset, gpio and filter reset on setup write
  a_dir_reset: assert property (!reset_pin_n [*6] |-> gpio_direction_bits == 4'hF && gpio_pin_oe == 4'h0)
    else $error("gpio not inputs in reset");
  a_reset_quiet: assert property (!reset_pin_n [*6] |-> data_ready_n && !converting)
    else $error("activity during reset");
  a_gpio_oe: assert property (gpio_write |-> ##2 gpio_pin_oe == ~$past(gpio_dir_wdata, 2))
    else $error("gpio enable differs from direction");
  a_gpio_out: assert property (gpio_write |-> ##2 (gpio_pin_out & gpio_pin_oe) ==
    ($past(gpio_level_wdata, 2) & ~$past(gpio_dir_wdata, 2)))
    else $error("gpio output level wrong");
  a_filter_rst: assert property (setup_write && converting |-> ##[1:4] filter_reset)
    else $error("setup write did not reset filter");
  c_frame: cover property ($fell(data_ready_n));
  c_cmd: cover property (cmd_valid);
  c_filter: cover property (filter_reset);
endmodule // adc_readout_checker
`default_nettype wire

// File: tb/host_spi_model.sv
// host side of the serial port: select, serial clock and input line
// assumes: half a serial period is HALF master clocks; clock idles low
`timescale 1ns/10ps
`default_nettype none
module host_spi_model #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  logic [255:0] rx;
  // idle bus at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // one transfer; released output is taken as unknown so it never matches
  task automatic xfer(input int n, input logic [7:0] cmd);
    logic [7:0] sh;
    sh = cmd;
    rx = '0;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      din <= sh[7];
      sh = {sh[6:0], 1'b0};
      repeat (HALF) @(posedge clk_sys);
      sclk <= 1'b0;
      repeat (HALF) @(posedge clk_sys);
      rx = {rx[254:0], (sdo_oe === 1'b1) ? sdo : 1'bx};
    end
    repeat (HALF) @(posedge clk_sys);
    cs_n <= 1'b1;
    repeat (2 * HALF) @(posedge clk_sys);
  endtask
endmodule // host_spi_model
`default_nettype wire

// File: tb/adc_readout_conversion_ctrl_test.sv
// self-checking bench for the readout and conversion control block
// assumes: checker and host model compiled first; settling shortened
`timescale 1ns/10ps
`default_nettype none
`include "adc_readout_map.vh"
module adc_readout_conversion_ctrl_test;
  logic clk_sys, reset_n = 1'b0, reset_pin_n = 1'b1, start_pin = 1'b0;
  logic gpio_write = 1'b0, setup_write = 1'b0, sample_valid = 1'b0;
  logic chain_enable_bit = 1'b0, one_conversion_mode_bit = 1'b0;
  logic [3:0] gpio_dir_wdata = 4'h0, gpio_level_wdata = 4'h0, gpio_ext = 4'h4;
  logic [7:0] chan_power_off = 8'h04, lead_off_pos_status = 8'h81;
  logic [7:0] lead_off_neg_status = 8'h3C;
  logic [1:0] channel_variant = 2'h2;
  logic [23:0] sample_data = 24'h000000;
  logic sclk, cs_n, din, sdo, sdo_oe, data_ready_n, sample_ready;
  logic filter_reset, converting, cmd_valid, seen;
  logic [3:0] gpio_pin_out, gpio_pin_oe, gpio_direction_bits, gpio_level_bits;
  wire logic [3:0] gpio_pin_in;
  logic [7:0] cmd_byte;
  logic [23:0] smp [0:7];
  logic [215:0] exp;
  int miscompares = 0, checks = 0, cycles = 0;
  // pins read back what drives them: the block when enabled, else the board
  assign gpio_pin_in = (gpio_pin_oe & gpio_pin_out) | (~gpio_pin_oe & gpio_ext);
  host_spi_model #(.HALF(4)) u_host (.clk_sys(clk_sys), .sdo(sdo), .sdo_oe(sdo_oe),
    .sclk(sclk), .cs_n(cs_n), .din(din));
  adc_readout_conversion_ctrl #(.SETTLE_STEP(16), .SETTLE_OFFSET(8)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
    .start_pin(start_pin), .sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo),
    .sdo_oe(sdo_oe), .data_ready_n(data_ready_n), .gpio_pin_in(gpio_pin_in),
    .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe), .gpio_write(gpio_write),
    .gpio_dir_wdata(gpio_dir_wdata), .gpio_level_wdata(gpio_level_wdata),
    .gpio_direction_bits(gpio_direction_bits), .gpio_level_bits(gpio_level_bits),
    .lead_off_pos_status(lead_off_pos_status), .lead_off_neg_status(lead_off_neg_status),
    .chan_power_off(chan_power_off), .channel_variant(channel_variant),
    .chain_enable_bit(chain_enable_bit), .one_conversion_mode_bit(one_conversion_mode_bit),
    .low_power_mode(1'b0), .rate_select(3'h0), .setup_write(setup_write),
    .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
    .filter_reset(filter_reset), .converting(converting), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid));
  // 100 MHz master clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input logic [255:0] got, input logic [255:0] want);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH %0t seen %h exp %h", $time, got, want);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // expected frame: marker, lead-off bits, gpio levels, eight slots
  function automatic logic [215:0] frame(input logic [3:0] lvl);
    logic [215:0] f;
    f = {`STATUS_MARK, lead_off_pos_status, lead_off_neg_status, lvl, 192'h0};
    for (int i = 0; i < `CH_COUNT; i++)
      if (!chan_power_off[i])
        f[191 - 24 * i -: 24] = smp[i];
    return f;
  endfunction
  task automatic fill();
    sample_valid <= 1'b1;
    for (int i = 0; i < `CH_COUNT; i++) begin
      sample_data <= smp[i];
      @(posedge clk_sys);
      while (sample_ready !== 1'b1) @(posedge clk_sys);
    end
    sample_valid <= 1'b0;
  endtask
  task automatic gpio_set(input logic [3:0] dir, input logic [3:0] lvl);
    gpio_dir_wdata <= dir;
    gpio_level_wdata <= lvl;
    gpio_write <= 1'b1;
    @(posedge clk_sys);
    gpio_write <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic wait_data_ready_n();
    for (int k = 0; k < 2000 && data_ready_n !== 1'b0; k++) @(posedge clk_sys);
    check(data_ready_n, 1'b0);
  endtask
  // main sequence
  initial begin
    for (int i = 0; i < `CH_COUNT; i++)
      smp[i] = 24'h912345 + 24'h101010 * 24'(i);
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check(gpio_direction_bits, 4'hF);
    check(gpio_pin_oe, 4'h0);
    check(sdo_oe, 1'b0);
    gpio_set(4'h0, 4'h5);
    check(gpio_pin_oe, 4'hF);
    check(gpio_level_bits, 4'h5);
    gpio_set(4'hC, 4'hF);
    check(gpio_pin_out & gpio_pin_oe, 4'h3);
    check(gpio_level_bits, 4'h7);
    // buffer fills with no start and must refuse; no data ready appears
    fill();
    repeat (20) @(posedge clk_sys);
    check(sample_ready, 1'b0);
    check(data_ready_n, 1'b1);
    start_pin <= 1'b1;
    wait_data_ready_n();
    check(sample_ready, 1'b1);
    exp = frame(4'h7);
    u_host.xfer(216, 8'h00);
    check(u_host.rx[215:0], exp);
    check(data_ready_n, 1'b1);
    for (int v = 0; v < 2; v++) begin
      channel_variant <= 2'(v);
      u_host.xfer(216, 8'h00);
      check(u_host.rx[215:0], exp & ({216{1'b1}} << (96 - 48 * v)));
    end
    channel_variant <= 2'h2;
    chain_enable_bit <= 1'b1;
    u_host.xfer(240, 8'h00);
    check(u_host.rx[239:0], {exp, exp[215:192]});
    chain_enable_bit <= 1'b0;
    // setup write while running
    check(converting, 1'b1);
    setup_write <= 1'b1;
    @(posedge clk_sys);
    setup_write <= 1'b0;
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk_sys);
      seen = seen | filter_reset;
    end
    check(seen, 1'b1);
    // opcodes with the start pin low
    start_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    u_host.xfer(8, `OP_START);
    check(cmd_byte, `OP_START);
    check(converting, 1'b1);
    u_host.xfer(8, `OP_STOP);
    check(cmd_byte, `OP_STOP);
    u_host.xfer(8, `OP_RESET);
    repeat (30) @(posedge clk_sys);
    check(gpio_direction_bits, 4'hF);
    // single conversion: data ready stays low until read
    one_conversion_mode_bit <= 1'b1;
    fill();
    start_pin <= 1'b1;
    wait_data_ready_n();
    repeat (200) @(posedge clk_sys);
    check(data_ready_n, 1'b0);
    u_host.xfer(216, 8'h00);
    check(u_host.rx[215:0], frame(4'h4));
    gpio_set(4'h0, 4'hA);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check(gpio_pin_oe, 4'h0);
    reset_pin_n <= 1'b1;
    repeat (30) @(posedge clk_sys);
    final_report();
  end
endmodule // adc_readout_conversion_ctrl_test
bind adc_readout_conversion_ctrl adc_readout_checker u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reset_pin_n(reset_pin_n), .start_pin(start_pin),
  .sclk(sclk), .cs_n(cs_n), .sdo_oe(sdo_oe), .data_ready_n(data_ready_n),
  .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe), .gpio_write(gpio_write),
  .gpio_dir_wdata(gpio_dir_wdata), .gpio_level_wdata(gpio_level_wdata),
  .gpio_direction_bits(gpio_direction_bits), .setup_write(setup_write),
  .filter_reset(filter_reset), .converting(converting), .cmd_valid(cmd_valid));
`default_nettype wire
